// ---- dma2_ctrl.sv ----
// Two-channel transfer controller: registers, enables and byte engine
`timescale 1ns/1ps
`include "dma2_cfg.svh"
// Operation
// RULE1: 16-bit counts, minus one per byte
// RULE2: Software loads counts before use
// RULE3: 20-bit channel 1 memory pointer
// RULE4: Channel 1 I/O pointer, select byte resets zero
// RULE5: Move only when channel and main enabled
// RULE6: Count zero clears channel enable
// RULE7: Interrupt when enable low and irq enabled
// RULE8: Enable written only with mask zero
// RULE9: Mask bits always read one
// RULE10: Writing enable one sets main enable
// RULE11: NMI clears main enable, rewrite resumes
// RULE12: Main enable not directly writable
// RULE13: Reset clears enables and irq enables
// RULE14: Channel 0 destination mode, resets 00
// RULE15: Channel 0 source mode, same encoding
// RULE16: Software never programs I/O to I/O
// RULE17: Memory copy timing bit, resets zero
// RULE18: Burst holds bus, steal yields cycle
// RULE19: I/O transfers paced by request
// RULE20: Wait fields reset to all ones
// RULE21: Request sense bits, zero is level
// RULE22: Fast peripherals need edge sensing
// RULE23: Channel 1 direction field resets zero
// RULE24: Direction decode, I/O pointer fixed
// RULE25: Select bit 3 makes pin timer output
// RULE26: Wait field value adds that many waits
module dma2_ctrl (
    input  wire logic                  core_clk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  ce_i,
    input  wire dma2_pkg::io_req_t     io_i,
    input  wire logic                  nmi_i,
    input  wire logic                  req0_i,
    input  wire logic                  req1_i,
    output logic [7:0]                 io_rdata_o,
    output logic                       irq_o,
    output logic                       bus_hold_o,
    output dma2_pkg::byte_xfer_t       xfer_o,
    output dma2_pkg::addr_mode_t       ch0_src_mode_o,
    output dma2_pkg::addr_mode_t       ch0_dst_mode_o,
    output logic [1:0]                 mem_wait_o,
    output logic [1:0]                 io_wait_o,
    output logic                       timer_out_sel_o
);
    ////////////////////////////////////////////////////////////////
    logic [15:0]            cnt0_q;
    logic [15:0]            cnt1_q;
    logic [19:0]            mptr1_q;
    logic [15:0]            iptr1_q;
    logic [7:0]             rsel1_q;
    logic                   de0_q;
    logic                   de1_q;
    logic                   channel0_done_irq_enable_q;
    logic                   channel1_done_irq_enable_q;
    logic                   dme_q;
    logic                   burst_q;
    logic [1:0]             sense_q;
    logic [1:0]             dir1_q;
    dma2_pkg::eng_state_t   state_q;
    logic [3:0]             cyc_q;
    logic                   act_q;
    logic                   pend0;
    logic                   pend1;
    logic                   byte_done;
    logic                   done0;
    logic                   done1;
    logic                   m2m0;
    logic                   go0;
    logic                   go1;
    logic                   st_wr;
    logic                   set0;
    logic                   set1;

    function automatic logic wr_hit(input dma2_pkg::io_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Machine cycle plus its wait states
    function automatic logic [3:0] cyc_len(input logic io, input logic [1:0] mw, input logic [1:0] iw);
        return `MC_CLKS + {2'h0, (io ? iw : mw)}; // [RULE26]
    endfunction

    ////////////////////////////////////////////////////////////////
    req_sense u_sense0 (
        .core_clk_i  (core_clk_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .edge_mode_i (sense_q[1]),
        .req_i       (req0_i),
        .ack_i       (done0),
        .pend_o      (pend0)
    );

    // Pin serves the timer when select bit 3 is set
    req_sense u_sense1 (
        .core_clk_i  (core_clk_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .edge_mode_i (sense_q[0]),
        .req_i       (req1_i && !rsel1_q[`RSEL1_TOUT]), // [RULE25]
        .ack_i       (done1),
        .pend_o      (pend1)
    );

    assign st_wr     = wr_hit(io_i, `OFS_STATUS);
    assign set0      = st_wr && !io_i.wdata[`ST_WM0] && io_i.wdata[`ST_DE0];
    assign set1      = st_wr && !io_i.wdata[`ST_WM1] && io_i.wdata[`ST_DE1];
    assign m2m0      = (ch0_src_mode_o != dma2_pkg::STEP_IO) && (ch0_dst_mode_o != dma2_pkg::STEP_IO);
    assign go0       = de0_q && dme_q && (m2m0 || pend0); // [RULE5] [RULE19]
    assign go1       = de1_q && dme_q && pend1; // [RULE5]
    assign byte_done = (state_q == dma2_pkg::ST_MOVE) && (cyc_q == 4'h1);
    assign done0     = ce_i && byte_done && !act_q;
    assign done1     = ce_i && byte_done && act_q;

    ////////////////////////////////////////////////////////////////
    // Software load wins over a decrement in the same cycle
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt0_q <= 16'h0000;
            cnt1_q <= 16'h0000;
        end
        else if (ce_i)
        begin
            if (wr_hit(io_i, `OFS_CNT0_LO))
                cnt0_q[7:0] <= io_i.wdata;
            else if (wr_hit(io_i, `OFS_CNT0_HI))
                cnt0_q[15:8] <= io_i.wdata;
            else if (done0)
                cnt0_q <= cnt0_q - 16'h0001; // [RULE1]
            if (wr_hit(io_i, `OFS_CNT1_LO))
                cnt1_q[7:0] <= io_i.wdata;
            else if (wr_hit(io_i, `OFS_CNT1_HI))
                cnt1_q[15:8] <= io_i.wdata;
            else if (done1)
                cnt1_q <= cnt1_q - 16'h0001; // [RULE1]
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mptr1_q <= 20'h00000;
            iptr1_q <= 16'h0000;
            rsel1_q <= `RSEL1_RST; // [RULE4]
        end
        else if (ce_i)
        begin
            if (wr_hit(io_i, `OFS_MPTR1_LO))
                mptr1_q[7:0] <= io_i.wdata;
            else if (wr_hit(io_i, `OFS_MPTR1_HI))
                mptr1_q[15:8] <= io_i.wdata;
            else if (wr_hit(io_i, `OFS_MPTR1_BK))
                mptr1_q[19:16] <= io_i.wdata[3:0]; // [RULE3]
            else if (done1)
                mptr1_q <= dir1_q[0] ? mptr1_q - 20'h00001 : mptr1_q + 20'h00001; // [RULE24]
            if (wr_hit(io_i, `OFS_IPTR1_LO))
                iptr1_q[7:0] <= io_i.wdata;
            if (wr_hit(io_i, `OFS_IPTR1_HI))
                iptr1_q[15:8] <= io_i.wdata;
            if (wr_hit(io_i, `OFS_RSEL1))
                rsel1_q <= io_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Software write wins over the terminal clear
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            de0_q  <= 1'b0; // [RULE13]
            de1_q  <= 1'b0;
            channel0_done_irq_enable_q <= 1'b0;
            channel1_done_irq_enable_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (st_wr && !io_i.wdata[`ST_WM0])
                de0_q <= io_i.wdata[`ST_DE0]; // [RULE8]
            else if (done0 && cnt0_q == 16'h0001)
                de0_q <= 1'b0; // [RULE6]
            if (st_wr && !io_i.wdata[`ST_WM1])
                de1_q <= io_i.wdata[`ST_DE1]; // [RULE8]
            else if (done1 && cnt1_q == 16'h0001)
                de1_q <= 1'b0; // [RULE6]
            if (st_wr)
            begin
                channel1_done_irq_enable_q <= io_i.wdata[`ST_CHANNEL1_DONE_IRQ_ENABLE];
                channel0_done_irq_enable_q <= io_i.wdata[`ST_CHANNEL0_DONE_IRQ_ENABLE];
            end
        end
    end

    // A fresh enable write in the NMI cycle keeps the engine running
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            dme_q <= 1'b0; // [RULE13]
        else if (ce_i)
        begin
            if (set0 || set1)
                dme_q <= 1'b1; // [RULE10] [RULE11]
            else if (nmi_i)
                dme_q <= 1'b0; // [RULE11] [RULE12]
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ch0_dst_mode_o <= dma2_pkg::STEP_INC; // [RULE14]
            ch0_src_mode_o <= dma2_pkg::STEP_INC; // [RULE15]
            burst_q        <= 1'b0; // [RULE17]
            mem_wait_o     <= `WAIT_RST; // [RULE20]
            io_wait_o      <= `WAIT_RST;
            sense_q        <= `SENSE_RST; // [RULE21]
            dir1_q         <= `DIR1_RST; // [RULE23]
        end
        else if (ce_i)
        begin
            if (wr_hit(io_i, `OFS_MODE0))
            begin
                ch0_dst_mode_o <= dma2_pkg::addr_mode_t'(io_i.wdata[5:4]);
                ch0_src_mode_o <= dma2_pkg::addr_mode_t'(io_i.wdata[3:2]);
                burst_q        <= io_i.wdata[1];
            end
            if (wr_hit(io_i, `OFS_WAITCTL))
            begin
                mem_wait_o <= io_i.wdata[7:6];
                io_wait_o  <= io_i.wdata[5:4];
                sense_q    <= io_i.wdata[3:2];
                dir1_q     <= io_i.wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Channel 0 has priority; a byte always completes once begun
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q    <= dma2_pkg::ST_IDLE;
            cyc_q      <= 4'h0;
            act_q      <= 1'b0;
            bus_hold_o <= 1'b0;
        end
        else if (ce_i)
        begin
            unique case (state_q)
                dma2_pkg::ST_IDLE:
                begin
                    if (go0)
                    begin
                        state_q    <= dma2_pkg::ST_MOVE;
                        act_q      <= 1'b0;
                        bus_hold_o <= 1'b1;
                        cyc_q      <= cyc_len(ch0_src_mode_o == dma2_pkg::STEP_IO, mem_wait_o, io_wait_o)
                                    + cyc_len(ch0_dst_mode_o == dma2_pkg::STEP_IO, mem_wait_o, io_wait_o);
                    end
                    else if (go1)
                    begin
                        state_q    <= dma2_pkg::ST_MOVE;
                        act_q      <= 1'b1;
                        bus_hold_o <= 1'b1;
                        cyc_q      <= cyc_len(1'b0, mem_wait_o, io_wait_o)
                                    + cyc_len(1'b1, mem_wait_o, io_wait_o); // [RULE24]
                    end
                end
                dma2_pkg::ST_MOVE:
                begin
                    if (cyc_q != 4'h1)
                        cyc_q <= cyc_q - 4'h1;
                    else if (!act_q && m2m0 && burst_q && cnt0_q != 16'h0001 && de0_q && dme_q)
                        cyc_q <= cyc_len(1'b0, mem_wait_o, io_wait_o) * 4'h2; // [RULE18]
                    else if (!act_q && m2m0 && !burst_q && cnt0_q != 16'h0001)
                    begin
                        state_q    <= dma2_pkg::ST_GAP; // [RULE18]
                        cyc_q      <= `MC_CLKS;
                        bus_hold_o <= 1'b0;
                    end
                    else
                    begin
                        state_q    <= dma2_pkg::ST_IDLE;
                        bus_hold_o <= 1'b0;
                    end
                end
                dma2_pkg::ST_GAP:
                begin
                    cyc_q <= cyc_q - 4'h1;
                    if (cyc_q == 4'h1)
                        state_q <= dma2_pkg::ST_IDLE;
                end
                default:
                begin
                    state_q    <= dma2_pkg::ST_IDLE;
                    bus_hold_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            xfer_o          <= '0;
            irq_o           <= 1'b0;
            timer_out_sel_o <= 1'b0;
            io_rdata_o      <= 8'h00;
        end
        else if (ce_i)
        begin
            xfer_o.stb      <= byte_done;
            xfer_o.ch       <= act_q;
            xfer_o.to_mem   <= dir1_q[1]; // [RULE24]
            xfer_o.mem_addr <= mptr1_q;
            xfer_o.io_addr  <= iptr1_q;
            irq_o           <= (!de1_q && channel1_done_irq_enable_q) || (!de0_q && channel0_done_irq_enable_q); // [RULE7]
            timer_out_sel_o <= rsel1_q[`RSEL1_TOUT]; // [RULE25]
            if (io_i.rd)
            begin
                unique case (io_i.addr)
                    `OFS_CNT0_LO:  io_rdata_o <= cnt0_q[7:0];
                    `OFS_CNT0_HI:  io_rdata_o <= cnt0_q[15:8];
                    `OFS_MPTR1_LO: io_rdata_o <= mptr1_q[7:0];
                    `OFS_MPTR1_HI: io_rdata_o <= mptr1_q[15:8];
                    `OFS_MPTR1_BK: io_rdata_o <= {4'h0, mptr1_q[19:16]};
                    `OFS_IPTR1_LO: io_rdata_o <= iptr1_q[7:0];
                    `OFS_IPTR1_HI: io_rdata_o <= iptr1_q[15:8];
                    `OFS_RSEL1:    io_rdata_o <= rsel1_q;
                    `OFS_CNT1_LO:  io_rdata_o <= cnt1_q[7:0];
                    `OFS_CNT1_HI:  io_rdata_o <= cnt1_q[15:8];
                    `OFS_STATUS:   io_rdata_o <= {de1_q, de0_q, 2'h3, channel1_done_irq_enable_q, channel0_done_irq_enable_q, 1'b0, dme_q}; // [RULE9]
                    `OFS_MODE0:    io_rdata_o <= {2'h0, ch0_dst_mode_o, ch0_src_mode_o, burst_q, 1'b0};
                    `OFS_WAITCTL:  io_rdata_o <= {mem_wait_o, io_wait_o, sense_q, dir1_q};
                    default:       io_rdata_o <= `UNMAPPED_RD;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_mask_read_one: assert property (ce_i && io_i.rd && io_i.addr == `OFS_STATUS // [RULE9]
        |=> io_rdata_o[5:4] == 2'h3) else $error("mask bits did not read one");
    a_main_not_direct: assert property (ce_i && st_wr && io_i.wdata[`ST_WM0] && io_i.wdata[`ST_WM1] && !nmi_i // [RULE12]
        |=> dme_q == $past(dme_q) && de0_q == $past(de0_q)) else $error("masked write changed enables");
    a_enable_sets_main: assert property (ce_i && set0 // [RULE10]
        |=> dme_q && de0_q) else $error("enable write did not set main enable");
    a_nmi_clears_main: assert property (ce_i && nmi_i && !set0 && !set1 // [RULE11]
        |=> !dme_q) else $error("NMI did not clear main enable");
    a_irq_on_done: assert property (ce_i && !de0_q && channel0_done_irq_enable_q // [RULE7]
        |=> irq_o) else $error("termination interrupt missing");
    a_idle_when_off: assert property (state_q == dma2_pkg::ST_IDLE && !dme_q // [RULE5]
        |=> state_q == dma2_pkg::ST_IDLE && !bus_hold_o) else $error("moved while disabled");
    a_count_step: assert property (done0 && !wr_hit(io_i, `OFS_CNT0_LO) && !wr_hit(io_i, `OFS_CNT0_HI) // [RULE1]
        |=> cnt0_q == $past(cnt0_q) - 16'h0001) else $error("count did not step by one");
    a_zero_stops: assert property (done0 && cnt0_q == 16'h0001 && !st_wr // [RULE6]
        |=> !de0_q ##1 !go0) else $error("channel 0 not stopped at zero");
    a_steal_gap: assert property (done0 && m2m0 && !burst_q && cnt0_q != 16'h0001 // [RULE18]
        |=> state_q == dma2_pkg::ST_GAP && !bus_hold_o) else $error("no CPU cycle in steal mode");
    a_burst_holds: assert property (done0 && m2m0 && burst_q && cnt0_q != 16'h0001 && de0_q && dme_q // [RULE18]
        |=> state_q == dma2_pkg::ST_MOVE && bus_hold_o) else $error("burst released the bus");
    a_io_paced: assert property (state_q == dma2_pkg::ST_IDLE && !m2m0 && !pend0 && !go1 // [RULE19]
        |=> state_q == dma2_pkg::ST_IDLE) else $error("I/O transfer started unrequested");

    c_burst_byte: cover property (done0 && burst_q && m2m0);
    c_steal_gap: cover property (state_q == dma2_pkg::ST_GAP);
    c_ch1_byte: cover property (done1);
    c_nmi_stop: cover property (nmi_i && dme_q);
endmodule

// ---- dma2_cfg.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef DMA2_CFG_SVH
`define DMA2_CFG_SVH

`define OFS_CNT0_LO   8'h26
`define OFS_CNT0_HI   8'h27
`define OFS_MPTR1_LO  8'h28
`define OFS_MPTR1_HI  8'h29
`define OFS_MPTR1_BK  8'h2a
`define OFS_IPTR1_LO  8'h2b
`define OFS_IPTR1_HI  8'h2c
`define OFS_RSEL1     8'h2d
`define OFS_CNT1_LO   8'h2e
`define OFS_CNT1_HI   8'h2f
`define OFS_STATUS    8'h30
`define OFS_MODE0     8'h31
`define OFS_WAITCTL   8'h32

`define ST_DE1        7
`define ST_DE0        6
`define ST_WM1        5
`define ST_WM0        4
`define ST_CHANNEL1_DONE_IRQ_ENABLE       3
`define ST_CHANNEL0_DONE_IRQ_ENABLE       2
`define ST_DME        0
`define RSEL1_TOUT    3

`define RSEL1_RST     8'h00
`define WAIT_RST      2'h3
`define SENSE_RST     2'h0
`define DIR1_RST      2'h0
`define UNMAPPED_RD   8'h00
`define MC_CLKS       4'h3

`endif

// ---- dma2_pkg.sv ----
// Types shared by the two-channel transfer controller
package dma2_pkg;
    typedef enum logic [1:0] {
        STEP_INC = 2'h0,
        STEP_DEC = 2'h1,
        STEP_FIX = 2'h2,
        STEP_IO  = 2'h3
    } addr_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_MOVE = 3'h2,
        ST_GAP  = 3'h4
    } eng_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic        stb;
        logic        ch;
        logic        to_mem;
        logic [19:0] mem_addr;
        logic [15:0] io_addr;
    } byte_xfer_t;
endpackage

// ---- req_sense.sv ----
// Level or edge qualification of one transfer request input
`timescale 1ns/1ps
module req_sense (
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic edge_mode_i,
    input  wire logic req_i,
    input  wire logic ack_i,
    output logic      pend_o
);
    logic prev_q;
    logic latch_q;

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            prev_q <= 1'b0;
        else if (ce_i)
            prev_q <= req_i;
    end

    // A new edge in the ack cycle is kept
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            latch_q <= 1'b0;
        else if (ce_i)
        begin
            if (req_i && !prev_q)
                latch_q <= 1'b1; // [RULE21]
            else if (ack_i)
                latch_q <= 1'b0;
        end
    end

    assign pend_o = edge_mode_i ? latch_q : req_i; // [RULE21]
endmodule

// ---- req_peer.sv ----
// Peripheral model that raises channel 1 transfer requests
`timescale 1ns/1ps
module req_peer (
    input  wire logic                 core_clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 en_i,
    input  wire logic [3:0]           gap_i,
    input  wire logic                 bus_hold_i,
    input  wire dma2_pkg::byte_xfer_t xfer_i,
    output logic                      req_o
);
    logic [3:0] wait_q;

    // Drops the request once the bus is taken, so level sense sees it low by byte end
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            req_o  <= 1'b0;
            wait_q <= 4'h0;
        end
        else if (!en_i || bus_hold_i)
        begin
            req_o <= 1'b0;
        end
        else if (xfer_i.stb && xfer_i.ch)
        begin
            wait_q <= gap_i;
        end
        else if (wait_q != 4'h0)
        begin
            wait_q <= wait_q - 4'h1;
        end
        else
        begin
            req_o <= 1'b1;
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench for the two-channel transfer controller
`timescale 1ns/1ps
module tb;
    logic                 core_clk_i;
    logic                 nrst_i;
    dma2_pkg::io_req_t    io_i;
    logic                 nmi_i;
    logic                 req0_i;
    logic                 req1;
    logic                 peer_en;
    logic [3:0]           peer_gap;
    logic [7:0]           io_rdata_o;
    logic                 irq_o;
    logic                 bus_hold_o;
    dma2_pkg::byte_xfer_t xfer_o;
    dma2_pkg::addr_mode_t src_mode;
    dma2_pkg::addr_mode_t dst_mode;
    logic [1:0]           mem_wait_o;
    logic [1:0]           io_wait_o;
    logic                 tsel;
    logic [31:0]          seed;
    logic [31:0]          r;
    logic [7:0]           v;
    logic [19:0]          mptr;
    logic [15:0]          iptr;
    logic [19:0]          expq[$];
    logic                 en1, en0, men, ie1, ie0, was_hold;
    int                   miscompares, total_checks, rises, hold_n, mw, iw, dir;

    dma2_ctrl dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .io_i(io_i),
        .nmi_i(nmi_i), .req0_i(req0_i), .req1_i(req1), .io_rdata_o(io_rdata_o), .irq_o(irq_o),
        .bus_hold_o(bus_hold_o), .xfer_o(xfer_o), .ch0_src_mode_o(src_mode),
        .ch0_dst_mode_o(dst_mode), .mem_wait_o(mem_wait_o), .io_wait_o(io_wait_o),
        .timer_out_sel_o(tsel));

    req_peer peer_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .en_i(peer_en), .gap_i(peer_gap),
        .bus_hold_i(bus_hold_o), .xfer_i(xfer_o), .req_o(req1));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] stat();
        return {en1, en0, 2'b11, ie1, ie0, 1'b0, men};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        io_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk_i);
        io_i = '0;
    endtask

    task automatic get(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge core_clk_i);
        io_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk_i);
        io_i = '0;
        @(posedge core_clk_i);
        #1;
        chk(what, exp, io_rdata_o);
    endtask

    // Mirror of the enable logic: mask bit high keeps the enable as it was
    task automatic wstat(input logic [7:0] d);
        put(8'h30, d);
        ie1 = d[3];
        ie0 = d[2];
        if (!d[5])
            en1 = d[7];
        if (!d[4])
            en0 = d[6];
        if ((!d[5] && d[7]) || (!d[4] && d[6]))
            men = 1'b1;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        repeat (2) @(negedge core_clk_i);
        while (irq_o !== 1'b1 && n < 3000)
        begin
            @(negedge core_clk_i);
            n++;
        end
        chk("done irq", 1, irq_o);
    endtask

    task automatic ch1_run(input int d, input int cnt);
        r = rnd();
        mptr = r[19:0];
        iptr = r[31:16];
        dir = d;
        peer_gap = r[27:24];
        put(8'h32, {mw[1:0], iw[1:0], 2'b00, d[1:0]});
        put(8'h2d, 8'h00);
        put(8'h28, mptr[7:0]);
        put(8'h29, mptr[15:8]);
        put(8'h2a, {4'h0, mptr[19:16]});
        put(8'h2b, iptr[7:0]);
        put(8'h2c, iptr[15:8]);
        put(8'h2e, cnt[7:0]);
        put(8'h2f, 8'h00);
        for (int i = 0; i < cnt; i++)
            expq.push_back(d[0] ? mptr - i[19:0] : mptr + i[19:0]);
        peer_en = 1'b1;
        wstat(8'h98);
        get(8'h30, stat(), "status");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    always @(posedge core_clk_i)
    begin
        #1;
        if (bus_hold_o === 1'b1)
            hold_n++;
        if (bus_hold_o === 1'b1 && was_hold !== 1'b1)
            rises++;
        was_hold = bus_hold_o;
        if (xfer_o.stb === 1'b1 && xfer_o.ch === 1'b1)
        begin
            chk("hold cycles", 6 + mw + iw, hold_n);
            chk("mem addr", expq.pop_front(), xfer_o.mem_addr);
            chk("io addr", iptr, xfer_o.io_addr);
            chk("to mem", dir >> 1, xfer_o.to_mem);
        end
        if (xfer_o.stb === 1'b1)
            hold_n = 0;
    end

    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        #400000;
        miscompares++;
        $display("Error watchdog expected done seen timeout");
        results();
    end

    initial
    begin
        io_i = '0;
        {nmi_i, req0_i, peer_en, nrst_i} = 4'h0;
        peer_gap = 4'h0;
        seed = 32'hf4cf;
        {en1, en0, men, ie1, ie0, was_hold} = 6'h00;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        nrst_i = 1'b1;
        get(8'h30, 8'h30, "status");
        get(8'h31, 8'h00, "mode0");
        get(8'h32, 8'hf0, "waitctl");
        get(8'h2d, 8'h00, "rsel");
        get(8'h40, 8'h00, "unmapped");
        chk("wait ports", 4'hf, {mem_wait_o, io_wait_o});
        $display("reset test done");
        // Code 15 would be I/O on both sides, which software never sets
        for (int m = 0; m < 15; m++)
        begin
            r = rnd();
            v = {2'b00, m[3:0], r[0], 1'b0};
            put(8'h31, v);
            get(8'h31, v, "mode0");
            chk("dst mode", v[5:4], dst_mode);
            chk("src mode", v[3:2], src_mode);
        end
        for (int k = 0; k < 3; k++)
        begin
            r = rnd();
            put(8'h32, r[7:0]);
            get(8'h32, r[7:0], "waitctl");
            chk("wait ports", r[7:4], {mem_wait_o, io_wait_o});
            put(8'h2d, r[15:8]);
            @(negedge core_clk_i);
            chk("timer select", r[11], tsel);
            for (int a = 8'h26; a < 8'h30; a++)
            begin
                if (a == 8'h2d)
                    continue;
                r = rnd();
                put(a[7:0], r[7:0]);
                get(a[7:0], (a == 8'h2a) ? {4'h0, r[3:0]} : r[7:0], "ptr or count");
            end
        end
        wstat(8'hff);
        get(8'h30, stat(), "status");
        chk("irq", 1, irq_o);
        $display("register test done");
        for (int d = 0; d < 4; d++)
        begin
            r = rnd();
            mw = r[1:0];
            iw = r[3:2];
            ch1_run(d, 3);
            wait_irq();
            en1 = 1'b0;
            get(8'h30, stat(), "status");
            get(8'h2e, 8'h00, "count1");
            chk("bytes left", 0, expq.size());
        end
        peer_en = 1'b0;
        for (int b = 0; b < 2; b++)
        begin
            put(8'h31, {6'h00, b[0], 1'b0});
            put(8'h26, 8'h03);
            put(8'h27, 8'h00);
            rises = 0;
            wstat(8'h64);
            wait_irq();
            en0 = 1'b0;
            get(8'h30, stat(), "status");
            chk("bus grabs", b ? 1 : 3, rises);
        end
        put(8'h31, 8'h0c);
        put(8'h32, 8'h08);
        put(8'h26, 8'h02);
        put(8'h27, 8'h00);
        rises = 0;
        wstat(8'h64);
        repeat (30) @(negedge core_clk_i);
        chk("grabs without request", 0, rises);
        // Held high far longer than a byte: edge sense must give one byte only
        req0_i = 1'b1;
        repeat (60) @(negedge core_clk_i);
        req0_i = 1'b0;
        chk("grabs on one edge", 1, rises);
        get(8'h26, 8'h01, "count0");
        @(negedge core_clk_i);
        req0_i = 1'b1;
        wait_irq();
        req0_i = 1'b0;
        en0 = 1'b0;
        chk("grabs total", 2, rises);
        $display("channel test done");
        mw = 3;
        iw = 3;
        ch1_run(2, 8);
        repeat (20) @(negedge core_clk_i);
        nmi_i = 1'b1;
        @(negedge core_clk_i);
        nmi_i = 1'b0;
        men = 1'b0;
        repeat (40) @(negedge core_clk_i);
        v = rises;
        get(8'h30, stat(), "status");
        repeat (80) @(negedge core_clk_i);
        chk("grabs while halted", v, rises);
        wstat(8'h98);
        wait_irq();
        chk("bytes left", 0, expq.size());
        $display("halt test done");
        results();
    end
endmodule
